// *** hdl/enp_pkg.sv ***
// Package with the map, field layout and types of the equalizer, notch, PLL and input path register bank.
package enp_pkg;

  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned DATA_W   = 9;
  localparam int unsigned NUM_REGS = 17;
  localparam int unsigned IDX_W    = 5;
  localparam int unsigned NUM_BANDS = 4;

  localparam logic [ADDR_W-1:0] EQ_BAND2_CTRL_ADDR         = 7'h33;
  localparam logic [ADDR_W-1:0] EQ_BAND3_CTRL_ADDR         = 7'h34;
  localparam logic [ADDR_W-1:0] EQ_BAND4_CTRL_ADDR         = 7'h35;
  localparam logic [ADDR_W-1:0] EQ_BAND5_CTRL_ADDR         = 7'h36;
  localparam logic [ADDR_W-1:0] ANALOG_TEST_SELECT_ADDR    = 7'h37;
  localparam logic [ADDR_W-1:0] NOTCH_A0_HIGH_ADDR         = 7'h3B;
  localparam logic [ADDR_W-1:0] NOTCH_A0_LOW_ADDR          = 7'h3C;
  localparam logic [ADDR_W-1:0] NOTCH_A1_HIGH_ADDR         = 7'h3D;
  localparam logic [ADDR_W-1:0] NOTCH_A1_LOW_ADDR          = 7'h3E;
  localparam logic [ADDR_W-1:0] PLL_SET_A_PRESCALE_INT_ADDR = 7'h44;
  localparam logic [ADDR_W-1:0] PLL_SET_A_FRAC_HIGH_ADDR   = 7'h45;
  localparam logic [ADDR_W-1:0] PLL_SET_A_FRAC_MID_ADDR    = 7'h46;
  localparam logic [ADDR_W-1:0] PLL_SET_A_FRAC_LOW_ADDR    = 7'h47;
  localparam logic [ADDR_W-1:0] LEFT_INPUT_ROUTE_ADDR      = 7'h4B;
  localparam logic [ADDR_W-1:0] RIGHT_INPUT_ROUTE_ADDR     = 7'h4C;
  localparam logic [ADDR_W-1:0] LEFT_STAGE2_GAIN_ADDR      = 7'h4D;
  localparam logic [ADDR_W-1:0] RIGHT_STAGE2_GAIN_ADDR     = 7'h4E;

  // Storage slot of each register; bands three to five take slots 1 to 3 after IDX_EQ_BAND2.
  localparam logic [IDX_W-1:0] IDX_EQ_BAND2    = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ANALOG_TEST = 5'h04;
  localparam logic [IDX_W-1:0] IDX_NOTCH_A0_HI = 5'h05;
  localparam logic [IDX_W-1:0] IDX_NOTCH_A0_LO = 5'h06;
  localparam logic [IDX_W-1:0] IDX_NOTCH_A1_HI = 5'h07;
  localparam logic [IDX_W-1:0] IDX_NOTCH_A1_LO = 5'h08;
  localparam logic [IDX_W-1:0] IDX_PLL_PRE_INT = 5'h09;
  localparam logic [IDX_W-1:0] IDX_PLL_FRAC_HI = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_PLL_FRAC_MD = 5'h0B;
  localparam logic [IDX_W-1:0] IDX_PLL_FRAC_LO = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_LEFT_ROUTE  = 5'h0D;
  localparam logic [IDX_W-1:0] IDX_RIGHT_ROUTE = 5'h0E;
  localparam logic [IDX_W-1:0] IDX_LEFT_GAIN   = 5'h0F;
  localparam logic [IDX_W-1:0] IDX_RIGHT_GAIN  = 5'h10;

  // Writable bits of each slot, in slot order.
  localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
    9'h17F, 9'h17F, 9'h17F, 9'h17F, 9'h1FF,
    9'h1FF, 9'h17F, 9'h17F, 9'h17F,
    9'h01F, 9'h03F, 9'h1FF, 9'h1FF,
    9'h067, 9'h067, 9'h03F, 9'h03F};

  localparam logic [DATA_W-1:0] REG_RESET = 9'h000;

  // Field positions.
  localparam int unsigned EQ_WIDTH_BIT    = 8;
  localparam int unsigned EQ_FREQ_LSB     = 5;
  localparam int unsigned NOTCH_UPD_BIT   = 8;
  localparam int unsigned NOTCH_EN_BIT    = 7;
  localparam int unsigned PLL_PRESCALE_BIT = 4;
  localparam int unsigned ROUTE_POS1_BIT  = 0;
  localparam int unsigned ROUTE_NEG1_BIT  = 1;
  localparam int unsigned ROUTE_AUX1_BIT  = 2;
  localparam int unsigned ROUTE_NEG2_BIT  = 5;
  localparam int unsigned ROUTE_AUX2_BIT  = 6;

  localparam logic [4:0] EQ_GAIN_MAX_CODE = 5'h18;
  localparam logic signed [5:0] EQ_GAIN_TOP_DB = 6'sh0C;

  // Band frequency in Hz per band and code.
  localparam logic [15:0] EQ_FREQ_HZ_TABLE [NUM_BANDS][4] = '{
    '{16'h00E6, 16'h012C, 16'h0181, 16'h01F4},
    '{16'h028A, 16'h0352, 16'h044C, 16'h0578},
    '{16'h0708, 16'h0960, 16'h0C80, 16'h1004},
    '{16'h14B4, 16'h1AF4, 16'h2328, 16'h2DB4}};

  typedef struct packed {
    logic       width_sel;
    logic [1:0] freq_sel;
    logic [4:0] gain;
  } enp_eq_band_t;

  typedef struct packed {
    logic aux_to_stage2;
    logic neg_to_stage2;
    logic aux_to_stage1;
    logic neg_mic_to_stage1;
    logic pos_mic_to_stage1;
  } enp_route_t;

endpackage : enp_pkg

// *** hdl/enp_config_regs.sv ***
// Register bank for equalizer bands two to five, notch filter, PLL set A and input path controls.
// How it works
// - Band bit 8 picks narrow or wide.
// - Gain code 0 is +12dB, 24 is -12dB.
// - Band two frequency 230 to 500 Hz.
// - Band three frequency 650 to 1400 Hz.
// - Band four frequency 1.8 to 4.1 kHz.
// - Band five cut-off 5.3 to 11.7 kHz.
// - Notch runs only while enable bit set.
// - Coefficient high seven bits first, low second.
// - Update bit pulse applies all coefficients together.
// - Update bit held high keeps applying coefficients.
// - Prescale bit divides reference clock by two.
// - Fractional coefficient assembled from three registers.
// - Left route bits drive left input switches.
// - Right route mirrors left with right pins.
// - Six-bit stage-two gains, bits 6 to 8 unused.
`timescale 1ns/1ps

module enp_config_regs
(
  // Clock and reset.
  input  wire logic                                 REF_CLK,
  input  wire logic                                 SYS_RST,
  // Control port word access.
  input  wire logic [enp_pkg::ADDR_W-1:0]           CTRL_ADDR,
  input  wire logic [enp_pkg::DATA_W-1:0]           CTRL_WDATA,
  input  wire logic                                 CTRL_WR_EN,
  input  wire logic                                 CTRL_RD_EN,
  output logic      [enp_pkg::DATA_W-1:0]           CTRL_RDATA,
  output logic                                      CTRL_RD_VALID,
  // Equalizer bands two to five, element 0 is band two.
  output enp_pkg::enp_eq_band_t [enp_pkg::NUM_BANDS-1:0] EQ_BAND,
  output logic [enp_pkg::NUM_BANDS-1:0][15:0]       EQ_FREQ_HZ,
  output logic [enp_pkg::NUM_BANDS-1:0][5:0]        EQ_GAIN_DB,
  output logic [enp_pkg::NUM_BANDS-1:0]             EQ_GAIN_RESERVED,
  // Analog test selection.
  output logic [8:0]                                ANALOG_TEST_CODE,
  // Notch filter.
  output logic                                      NOTCH_ENABLE,
  output logic [13:0]                               NOTCH_COEFF_ZERO,
  output logic [13:0]                               NOTCH_COEFF_ONE,
  output logic                                      NOTCH_APPLY,
  // PLL coefficient set A.
  output logic                                      PLL_REF_PRESCALE,
  output logic [3:0]                                PLL_INT_COEFF_SET_A,
  output logic [23:0]                               PLL_FRAC_COEFF_SET_A,
  // Input path switches and stage-two gains.
  output enp_pkg::enp_route_t                       LEFT_ROUTE,
  output enp_pkg::enp_route_t                       RIGHT_ROUTE,
  output logic [5:0]                                LEFT_STAGE2_GAIN_CODE,
  output logic [5:0]                                RIGHT_STAGE2_GAIN_CODE
);

  import enp_pkg::*;

  logic [DATA_W-1:0] regs_reg [NUM_REGS];
  logic              upd_prev_reg;
  logic              upd_any;
  logic              apply_now;
  logic [IDX_W:0]    acc_slot;
  logic              acc_hit;
  logic [IDX_W-1:0]  acc_idx;

  // Maps an address to its storage slot, with a hit flag on top.
  function automatic logic [IDX_W:0] slot_of(input logic [ADDR_W-1:0] addr);
    logic [IDX_W:0] r;
    r = {1'b0, 5'h00};
    case (addr)
      EQ_BAND2_CTRL_ADDR:          r = {1'b1, 5'h00};
      EQ_BAND3_CTRL_ADDR:          r = {1'b1, 5'h01};
      EQ_BAND4_CTRL_ADDR:          r = {1'b1, 5'h02};
      EQ_BAND5_CTRL_ADDR:          r = {1'b1, 5'h03};
      ANALOG_TEST_SELECT_ADDR:     r = {1'b1, IDX_ANALOG_TEST};
      NOTCH_A0_HIGH_ADDR:          r = {1'b1, IDX_NOTCH_A0_HI};
      NOTCH_A0_LOW_ADDR:           r = {1'b1, IDX_NOTCH_A0_LO};
      NOTCH_A1_HIGH_ADDR:          r = {1'b1, IDX_NOTCH_A1_HI};
      NOTCH_A1_LOW_ADDR:           r = {1'b1, IDX_NOTCH_A1_LO};
      PLL_SET_A_PRESCALE_INT_ADDR: r = {1'b1, IDX_PLL_PRE_INT};
      PLL_SET_A_FRAC_HIGH_ADDR:    r = {1'b1, IDX_PLL_FRAC_HI};
      PLL_SET_A_FRAC_MID_ADDR:     r = {1'b1, IDX_PLL_FRAC_MD};
      PLL_SET_A_FRAC_LOW_ADDR:     r = {1'b1, IDX_PLL_FRAC_LO};
      LEFT_INPUT_ROUTE_ADDR:       r = {1'b1, IDX_LEFT_ROUTE};
      RIGHT_INPUT_ROUTE_ADDR:      r = {1'b1, IDX_RIGHT_ROUTE};
      LEFT_STAGE2_GAIN_ADDR:       r = {1'b1, IDX_LEFT_GAIN};
      RIGHT_STAGE2_GAIN_ADDR:      r = {1'b1, IDX_RIGHT_GAIN};
      default:                     r = {1'b0, 5'h00};
    endcase
    return r;
  endfunction : slot_of

  // Converts a gain code to signed dB in 1 dB steps, reserved codes give 0 dB.
  function automatic logic [5:0] gain_db_of(input logic [4:0] code);
    logic [5:0] r;
    r = 6'h00;
    if (code <= EQ_GAIN_MAX_CODE)
    begin
      r = 6'(EQ_GAIN_TOP_DB - $signed({1'b0, code}));
    end
    return r;
  endfunction : gain_db_of

  // Route switch controls from one route register.
  function automatic enp_route_t route_of(input logic [DATA_W-1:0] value);
    enp_route_t r;
    r.pos_mic_to_stage1 = value[ROUTE_POS1_BIT];
    r.neg_mic_to_stage1 = value[ROUTE_NEG1_BIT];
    r.aux_to_stage1     = value[ROUTE_AUX1_BIT];
    r.neg_to_stage2     = value[ROUTE_NEG2_BIT];
    r.aux_to_stage2     = value[ROUTE_AUX2_BIT];
    return r;
  endfunction : route_of

  // Joins the seven-bit halves of one notch coefficient, high half first.
  function automatic logic [13:0] coeff_of(input logic [DATA_W-1:0] high, input logic [DATA_W-1:0] low);
    return {high[6:0], low[6:0]};
  endfunction : coeff_of

  assign acc_slot = slot_of(CTRL_ADDR);
  assign acc_hit  = acc_slot[IDX_W];
  assign acc_idx  = acc_slot[IDX_W-1:0];

  // Register writes keep only defined bits.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_reg[i] <= REG_RESET;
      end
    end
    else if (CTRL_WR_EN && acc_hit)
    begin
      regs_reg[acc_idx] <= CTRL_WDATA & REG_MASK[acc_idx];
    end
  end

  // Read valid follows the read strobe by one cycle.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      CTRL_RD_VALID <= 1'b0;
    end
    else
    begin
      CTRL_RD_VALID <= CTRL_RD_EN;
    end
  end

  // Read data holds until the next read, unmapped addresses read zero.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      CTRL_RDATA <= 9'h000;
    end
    else if (CTRL_RD_EN)
    begin
      CTRL_RDATA <= acc_hit ? regs_reg[acc_idx] : 9'h000;
    end
  end

  // Equalizer band fields as stored.
  genvar b;
  generate
    for (b = 0; b < NUM_BANDS; b++)
    begin : g_band
      always_ff @(posedge REF_CLK)
      begin
        if (SYS_RST)
        begin
          EQ_BAND[b] <= '0;
        end
        else
        begin
          EQ_BAND[b].width_sel <= regs_reg[b][EQ_WIDTH_BIT];
          EQ_BAND[b].freq_sel  <= regs_reg[b][EQ_FREQ_LSB +: 2];
          EQ_BAND[b].gain      <= regs_reg[b][4:0];
        end
      end

      // Band frequency in Hz from the frequency code.
      always_ff @(posedge REF_CLK)
      begin
        if (SYS_RST)
        begin
          EQ_FREQ_HZ[b] <= EQ_FREQ_HZ_TABLE[b][0];
        end
        else
        begin
          EQ_FREQ_HZ[b] <= EQ_FREQ_HZ_TABLE[b][regs_reg[b][EQ_FREQ_LSB +: 2]];
        end
      end

      // Band gain in dB and the reserved code flag.
      always_ff @(posedge REF_CLK)
      begin
        if (SYS_RST)
        begin
          EQ_GAIN_DB[b]       <= 6'h00;
          EQ_GAIN_RESERVED[b] <= 1'b0;
        end
        else
        begin
          EQ_GAIN_DB[b]       <= gain_db_of(regs_reg[b][4:0]);
          EQ_GAIN_RESERVED[b] <= (regs_reg[b][4:0] > EQ_GAIN_MAX_CODE);
        end
      end
    end
  endgenerate

  // Analog test code passes straight through.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ANALOG_TEST_CODE <= 9'h000;
    end
    else
    begin
      ANALOG_TEST_CODE <= regs_reg[IDX_ANALOG_TEST];
    end
  end

  // Any update bit high, or the cycle after the last one drops, applies the coefficients.
  always_comb
  begin
    upd_any = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      upd_any = upd_any | regs_reg[IDX_NOTCH_A0_HI + 5'(i)][NOTCH_UPD_BIT];
    end
  end

  assign apply_now = upd_any | upd_prev_reg;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      upd_prev_reg <= 1'b0;
    end
    else
    begin
      upd_prev_reg <= upd_any;
    end
  end

  // Apply strobe marks the cycles in which the active coefficients were reloaded.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      NOTCH_APPLY <= 1'b0;
    end
    else
    begin
      NOTCH_APPLY <= apply_now;
    end
  end

  // Active notch coefficients, loaded only on apply so all four fields move together.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      NOTCH_COEFF_ZERO <= 14'h0000;
      NOTCH_COEFF_ONE  <= 14'h0000;
    end
    else if (apply_now)
    begin
      NOTCH_COEFF_ZERO <= coeff_of(regs_reg[IDX_NOTCH_A0_HI], regs_reg[IDX_NOTCH_A0_LO]);
      NOTCH_COEFF_ONE  <= coeff_of(regs_reg[IDX_NOTCH_A1_HI], regs_reg[IDX_NOTCH_A1_LO]);
    end
  end

  // Notch enable follows its register bit directly.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      NOTCH_ENABLE <= 1'b0;
    end
    else
    begin
      NOTCH_ENABLE <= regs_reg[IDX_NOTCH_A0_HI][NOTCH_EN_BIT];
    end
  end

  // PLL set A prescale and integer coefficient.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      PLL_REF_PRESCALE    <= 1'b0;
      PLL_INT_COEFF_SET_A <= 4'h0;
    end
    else
    begin
      PLL_REF_PRESCALE    <= regs_reg[IDX_PLL_PRE_INT][PLL_PRESCALE_BIT];
      PLL_INT_COEFF_SET_A <= regs_reg[IDX_PLL_PRE_INT][3:0];
    end
  end

  // PLL set A fractional coefficient from its three registers.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      PLL_FRAC_COEFF_SET_A <= 24'h000000;
    end
    else
    begin
      PLL_FRAC_COEFF_SET_A <= {regs_reg[IDX_PLL_FRAC_HI][5:0],
                               regs_reg[IDX_PLL_FRAC_MD],
                               regs_reg[IDX_PLL_FRAC_LO]};
    end
  end

  // Input path switches.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      LEFT_ROUTE  <= '0;
      RIGHT_ROUTE <= '0;
    end
    else
    begin
      LEFT_ROUTE  <= route_of(regs_reg[IDX_LEFT_ROUTE]);
      RIGHT_ROUTE <= route_of(regs_reg[IDX_RIGHT_ROUTE]);
    end
  end

  // Stage-two gains.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      LEFT_STAGE2_GAIN_CODE  <= 6'h00;
      RIGHT_STAGE2_GAIN_CODE <= 6'h00;
    end
    else
    begin
      LEFT_STAGE2_GAIN_CODE  <= regs_reg[IDX_LEFT_GAIN][5:0];
      RIGHT_STAGE2_GAIN_CODE <= regs_reg[IDX_RIGHT_GAIN][5:0];
    end
  end

endmodule : enp_config_regs

// *** bench/enp_config_regs_monitor.sv ***
// Checker of the register bank outputs against control port traffic.
`timescale 1ns/1ps
module enp_config_regs_monitor
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Control port.
  input wire logic [enp_pkg::ADDR_W-1:0] CTRL_ADDR,
  input wire logic [enp_pkg::DATA_W-1:0] CTRL_WDATA,
  input wire logic CTRL_WR_EN,
  input wire logic CTRL_RD_EN,
  input wire logic [enp_pkg::DATA_W-1:0] CTRL_RDATA,
  input wire logic CTRL_RD_VALID,
  // Decoded outputs.
  input wire enp_pkg::enp_eq_band_t [enp_pkg::NUM_BANDS-1:0] EQ_BAND,
  input wire logic NOTCH_ENABLE,
  input wire logic [13:0] NOTCH_COEFF_ZERO,
  input wire logic NOTCH_APPLY,
  input wire logic PLL_REF_PRESCALE,
  input wire logic [23:0] PLL_FRAC_COEFF_SET_A,
  input wire enp_pkg::enp_route_t LEFT_ROUTE,
  input wire logic [5:0] LEFT_STAGE2_GAIN_CODE
);
  import enp_pkg::*;
  logic [8:0] wd1_reg;
  logic [8:0] wd2_reg;
  wire logic w33 = CTRL_WR_EN && CTRL_ADDR == 7'h33;
  wire logic w3b = CTRL_WR_EN && CTRL_ADDR == 7'h3B;
  wire logic w44 = CTRL_WR_EN && CTRL_ADDR == 7'h44;
  wire logic w45 = CTRL_WR_EN && CTRL_ADDR == 7'h45;
  wire logic w4b = CTRL_WR_EN && CTRL_ADDR == 7'h4B;
  wire logic w4d = CTRL_WR_EN && CTRL_ADDR == 7'h4D;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // Write data delayed to the edge where decoded outputs settle.
  always_ff @(posedge REF_CLK)
  begin
    wd1_reg <= CTRL_WDATA;
    wd2_reg <= wd1_reg;
  end
  band_fields_a: assert property (w33 |=> ##1 EQ_BAND[0] == {wd2_reg[8], wd2_reg[6:0]})
    else $error("band fields wrong");
  notch_enable_a: assert property (w3b |=> ##1 NOTCH_ENABLE == wd2_reg[7])
    else $error("notch enable wrong");
  notch_apply_a: assert property (w3b && CTRL_WDATA[8] |=> ##1 NOTCH_APPLY && NOTCH_COEFF_ZERO[13:7] == wd2_reg[6:0])
    else $error("notch reload missing");
  coeff_hold_a: assert property (!NOTCH_APPLY |-> $stable(NOTCH_COEFF_ZERO))
    else $error("coefficient moved without update");
  ref_prescale_a: assert property (w44 |=> ##1 PLL_REF_PRESCALE == wd2_reg[4])
    else $error("prescale wrong");
  frac_high_a: assert property (w45 |=> ##1 PLL_FRAC_COEFF_SET_A[23:18] == wd2_reg[5:0])
    else $error("fraction high bits wrong");
  left_route_a: assert property (w4b |=> ##1 LEFT_ROUTE == {wd2_reg[6:5], wd2_reg[2:0]})
    else $error("left route wrong");
  stage2_gain_a: assert property (w4d |=> ##1 LEFT_STAGE2_GAIN_CODE == wd2_reg[5:0])
    else $error("stage two gain wrong");
  spare_read_a: assert property (CTRL_RD_EN && CTRL_ADDR == 7'h4D |=> CTRL_RD_VALID && CTRL_RDATA[8:6] == 3'h0)
    else $error("spare bits read nonzero");
endmodule : enp_config_regs_monitor

bind enp_config_regs enp_config_regs_monitor i_mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CTRL_ADDR(CTRL_ADDR),
  .CTRL_WDATA(CTRL_WDATA), .CTRL_WR_EN(CTRL_WR_EN), .CTRL_RD_EN(CTRL_RD_EN), .CTRL_RDATA(CTRL_RDATA),
  .CTRL_RD_VALID(CTRL_RD_VALID), .EQ_BAND(EQ_BAND), .NOTCH_ENABLE(NOTCH_ENABLE), .NOTCH_COEFF_ZERO(NOTCH_COEFF_ZERO),
  .NOTCH_APPLY(NOTCH_APPLY), .PLL_REF_PRESCALE(PLL_REF_PRESCALE), .PLL_FRAC_COEFF_SET_A(PLL_FRAC_COEFF_SET_A),
  .LEFT_ROUTE(LEFT_ROUTE), .LEFT_STAGE2_GAIN_CODE(LEFT_STAGE2_GAIN_CODE));

// *** bench/enp_host_model.sv ***
// Host controller model that issues word writes and reads on the control port.
`timescale 1ns/1ps
module enp_host_model
(
  // Clock.
  input wire logic clk,
  // Control port.
  output logic [6:0] addr,
  output logic [8:0] wdata,
  output logic       wr_en,
  output logic       rd_en,
  input wire logic [8:0] rdata,
  input wire logic       rd_valid
);
  import enp_pkg::*;
  initial
  begin
    addr = 7'h00;
    wdata = 9'h000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // Released lines show the inverse of the last value.
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic v, output logic [8:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    v = rd_valid;
    d = rdata;
  endtask : rd
endmodule : enp_host_model

// *** bench/tb_enp_config_regs.sv ***
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
module tb_enp_config_regs;
  import enp_pkg::*;
  logic ref_clk, sys_rst, wr_en, rd_en, rd_valid, n_en, n_apply, pll_pre;
  logic [6:0] addr;
  logic [8:0] wdata, rdata, ana_code;
  enp_eq_band_t [3:0] eq_band;
  logic [3:0][15:0] eq_hz;
  logic [3:0][5:0] eq_db;
  logic [3:0] eq_res;
  logic [13:0] n_c0, n_c1;
  logic [3:0] pll_int;
  logic [23:0] pll_frac;
  enp_route_t l_route, r_route;
  logic [5:0] l_gain, r_gain;
  int fails = 0;
  int cmp_count = 0;
  logic [15:0] hz [16] = '{16'h00E6, 16'h012C, 16'h0181, 16'h01F4, 16'h028A, 16'h0352, 16'h044C, 16'h0578,
    16'h0708, 16'h0960, 16'h0C80, 16'h1004, 16'h14B4, 16'h1AF4, 16'h2328, 16'h2DB4};

  enp_config_regs i_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CTRL_ADDR(addr), .CTRL_WDATA(wdata),
    .CTRL_WR_EN(wr_en), .CTRL_RD_EN(rd_en), .CTRL_RDATA(rdata), .CTRL_RD_VALID(rd_valid), .EQ_BAND(eq_band),
    .EQ_FREQ_HZ(eq_hz), .EQ_GAIN_DB(eq_db), .EQ_GAIN_RESERVED(eq_res), .ANALOG_TEST_CODE(ana_code),
    .NOTCH_ENABLE(n_en), .NOTCH_COEFF_ZERO(n_c0), .NOTCH_COEFF_ONE(n_c1), .NOTCH_APPLY(n_apply),
    .PLL_REF_PRESCALE(pll_pre), .PLL_INT_COEFF_SET_A(pll_int), .PLL_FRAC_COEFF_SET_A(pll_frac),
    .LEFT_ROUTE(l_route), .RIGHT_ROUTE(r_route), .LEFT_STAGE2_GAIN_CODE(l_gain), .RIGHT_STAGE2_GAIN_CODE(r_gain));
  enp_host_model i_host (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rd_valid(rd_valid));

  task automatic conclude();
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Write and wait for the decoded outputs to settle.
  task automatic put(input logic [6:0] a, input logic [8:0] d);
    i_host.wr(a, d);
    @(negedge ref_clk);
  endtask : put
  task automatic rchk(input logic [6:0] a, input logic [8:0] e);
    logic v;
    logic [8:0] d;
    i_host.rd(a, v, d);
    chk(v, 1'b1);
    chk(d, e);
  endtask : rchk
  task automatic t_eq();
    logic [8:0] d;
    for (int b = 0; b < 4; b++)
      for (int f = 0; f < 4; f++)
      begin
        d = {f[0], 1'b1, f[1:0], 5'(f * 8)};
        put(7'h33 + 7'(b), d);
        chk(eq_band[b], {d[8], d[6:0]});
        chk(eq_hz[b], hz[b * 4 + f]);
        chk(eq_db[b], 6'(6'h0C - 6'(f * 8)));
        chk(eq_res[b], 1'b0);
        rchk(7'h33 + 7'(b), d & 9'h17F);
      end
  endtask : t_eq
  task automatic t_notch();
    logic [13:0] c0, c1;
    c0 = 14'h3FD5;
    c1 = 14'h0123;
    put(7'h3C, {2'h0, c0[6:0]});
    put(7'h3D, {2'h0, c1[13:7]});
    put(7'h3E, {2'h0, c1[6:0]});
    put(7'h3B, {2'h1, c0[13:7]});
    chk(n_en, 1'b1);
    chk(n_c0, 14'h0000);
    put(7'h3E, {2'h2, c1[6:0]});
    put(7'h3E, {2'h0, c1[6:0]});
    @(negedge ref_clk);
    chk(n_c0, c0);
    chk(n_c1, c1);
    chk(n_apply, 1'b0);
    put(7'h3C, {2'h2, c0[6:0]});
    put(7'h3D, 9'h07F);
    chk(n_c1[13:7], 7'h7F);
    chk(n_apply, 1'b1);
    put(7'h3C, {2'h0, c0[6:0]});
    put(7'h3B, 9'h155);
    chk(n_c0, 14'h2AD5);
    put(7'h3B, 9'h000);
    chk(n_en, 1'b0);
  endtask : t_notch
  task automatic t_pll_route();
    put(7'h44, 9'h1F5);
    chk({pll_pre, pll_int}, 5'h15);
    rchk(7'h44, 9'h015);
    put(7'h44, 9'h005);
    chk(pll_pre, 1'b0);
    put(7'h45, 9'h1EA);
    put(7'h46, 9'h123);
    put(7'h47, 9'h0AB);
    chk(pll_frac, {6'h2A, 9'h123, 9'h0AB});
    put(7'h4B, 9'h1FF);
    chk(l_route, 5'h1F);
    rchk(7'h4B, 9'h067);
    put(7'h4C, 9'h045);
    chk(r_route, 5'h15);
    put(7'h4D, 9'h07F);
    chk(l_gain, 6'h3F);
    rchk(7'h4D, 9'h03F);
    put(7'h4E, 9'h02A);
    chk(r_gain, 6'h2A);
    put(7'h37, 9'h1A5);
    chk(ana_code, 9'h1A5);
    rchk(7'h37, 9'h1A5);
    put(7'h38, 9'h1FF);
    rchk(7'h38, 9'h000);
  endtask : t_pll_route

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial
  begin
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++)
      rchk(7'h3B + 7'(i), 9'h000);
    chk(eq_hz[0], 16'h00E6);
    chk(eq_hz[3], 16'h14B4);
    t_eq();
    t_notch();
    t_pll_route();
    conclude();
  end
endmodule : tb_enp_config_regs
